// ---- mdw_pkg.sv ----
// Purpose: Shared constants for the motor drive warning monitor
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes: Warning codes and reset values are plain defaults
package mdw_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_IOMON = 8'h08;
    localparam logic [7:0] ADR_UPPER = 8'h0C;
    localparam logic [7:0] ADR_LOWER = 8'h10;
    localparam logic [7:0] ADR_OVLD = 8'h14;
    localparam logic [7:0] ADR_TEMP = 8'h18;
    localparam logic [7:0] ADR_SPEED = 8'h1C;
    localparam logic [7:0] ADR_FUNC = 8'h20;
    localparam logic [7:0] ADR_HIST = 8'h24;
    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_ASSIGN = 2;
    localparam int CTRL_LOCK = 3;
    localparam int CTRL_HCLR = 4;
    localparam int CTRL_ARST = 5;
    // ****************************************
    // Reset values and sizes
    // ****************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] UPPER_RST = 16'h0FA0;
    localparam logic [15:0] LOWER_RST = 16'h0050;
    localparam logic [15:0] SPEED_RST = 16'h0050;
    localparam logic [15:0] DIAL_STEP = 16'h0001;
    localparam logic [7:0] OVLD_RST = 8'hC8;
    localparam logic [7:0] TEMP_RST = 8'h55;
    localparam logic [3:0] FUNC_RST = 4'h0;
    localparam logic [3:0] HIST_DEPTH = 4'h9;
    // ****************************************
    // Warning codes
    // ****************************************
    localparam logic [7:0] WCODE_HEAT = 8'h51;
    localparam logic [7:0] WCODE_LOAD = 8'h30;
    localparam logic [7:0] WCODE_OPER = 8'h6C;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 25000000;
    localparam int EDIT_TIMEOUT_MS = 10;
    localparam int EDIT_TO_CYC = CLK_HZ / 1000 * EDIT_TIMEOUT_MS;
    // External operation setting
    typedef enum logic [1:0] {EXT_OFF, EXT_ON, EXT_DIR} mdw_ext_type;
endpackage : mdw_pkg

// ---- mdw_sync.sv ----
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: Each bit is an independent level
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
module mdw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // ****************************************
    // Per-bit flop pair
    // ****************************************
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic s1_q;
        logic s2_q;
        // First stage feeds only the second
        always_ff @(posedge core_clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
            end
            else
            begin
                s1_q <= d_i[i];
                s2_q <= s1_q;
            end
        end
        assign q_o[i] = s2_q;
    end
endmodule : mdw_sync

// ---- mdw_monitor.sv ----
// Purpose: Warning output, warning history and run permission of a motor drive
// Assumes: Pins are asynchronous; temp_i and load_i come from same-clock logic
// Notes: Wishbone slave answers one cycle after the request is seen
`timescale 1ns/1ps
module mdw_monitor #(
    parameter int EDIT_TO_CYC = mdw_pkg::EDIT_TO_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Asynchronous pins
    input wire logic forward_run_in_i,
    input wire logic reverse_run_in_i,
    input wire logic panel_run_i,
    input wire logic dir_switch_i,
    input wire logic alarm_reset_in_i,
    input wire logic alarm_in_i,
    input wire logic dial_up_i,
    input wire logic dial_down_i,
    input wire logic dial_press_i,
    input wire logic [3:0] term_in_i,
    // Same-clock measurements
    input wire logic [7:0] temp_i,
    input wire logic [7:0] load_i,
    // Outputs
    output logic motor_run_o,
    output logic motor_dir_o,
    output logic [15:0] speed_cmd_o,
    output logic warning_out_o
);
    // ****************************************
    // Input synchronisation
    // ****************************************
    logic [12:0] pin_s;
    logic fwd_s, rev_s, panel_s, dsw_s, arst_s, alarm_s, up_s, dn_s, press_s;
    logic [3:0] term_s;
    mdw_sync #(.W(13)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .d_i({forward_run_in_i, reverse_run_in_i, panel_run_i, dir_switch_i,
              alarm_reset_in_i, alarm_in_i, dial_up_i, dial_down_i, dial_press_i,
              term_in_i}),
        .q_o(pin_s)
    );
    assign {fwd_s, rev_s, panel_s, dsw_s, arst_s, alarm_s, up_s, dn_s, press_s,
            term_s} = pin_s;

    // ****************************************
    // Wishbone decode
    // ****************************************
    logic [7:0] ctrl_q;
    logic [15:0] upper_q, lower_q, speed_set_q;
    logic [7:0] ovld_q, temp_lim_q;
    logic [3:0] func_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic req, wr, wr_ctrl, hclr, mon_arst;
    mdw_pkg::mdw_ext_type mode;
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i;
    assign wr_ctrl = wr && wb_adr_i == mdw_pkg::ADR_CTRL && wb_sel_i[0];
    assign hclr = wr_ctrl && wb_dat_i[mdw_pkg::CTRL_HCLR];
    assign mon_arst = wr_ctrl && wb_dat_i[mdw_pkg::CTRL_ARST];
    assign mode = mdw_pkg::mdw_ext_type'(ctrl_q[1:0]);

    // Setting registers, byte lanes honoured
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= mdw_pkg::CTRL_RST;
            upper_q <= mdw_pkg::UPPER_RST;
            lower_q <= mdw_pkg::LOWER_RST;
            ovld_q <= mdw_pkg::OVLD_RST;
            temp_lim_q <= mdw_pkg::TEMP_RST;
            func_q <= mdw_pkg::FUNC_RST;
        end
        else if (wr)
        begin
            if (wr_ctrl)
                ctrl_q <= {4'h0, wb_dat_i[3:0]}; // Command bits never stick
            if (wb_adr_i == mdw_pkg::ADR_UPPER && wb_sel_i[0])
                upper_q[7:0] <= wb_dat_i[7:0];
            if (wb_adr_i == mdw_pkg::ADR_UPPER && wb_sel_i[1])
                upper_q[15:8] <= wb_dat_i[15:8];
            if (wb_adr_i == mdw_pkg::ADR_LOWER && wb_sel_i[0])
                lower_q[7:0] <= wb_dat_i[7:0];
            if (wb_adr_i == mdw_pkg::ADR_LOWER && wb_sel_i[1])
                lower_q[15:8] <= wb_dat_i[15:8];
            if (wb_adr_i == mdw_pkg::ADR_OVLD && wb_sel_i[0])
                ovld_q <= wb_dat_i[7:0];
            if (wb_adr_i == mdw_pkg::ADR_TEMP && wb_sel_i[0])
                temp_lim_q <= wb_dat_i[7:0];
            if (wb_adr_i == mdw_pkg::ADR_FUNC && wb_sel_i[0])
                func_q <= wb_dat_i[3:0];
        end
    end

    // ****************************************
    // Warning causes
    // ****************************************
    logic heat_q, load_q, oper_q;
    logic [2:0] wprev_q;
    logic func_wr;
    logic [3:0] func_new;
    assign func_wr = wr && wb_adr_i == mdw_pkg::ADR_FUNC && wb_sel_i[0];
    assign func_new = wb_dat_i[3:0] & ~func_q & term_s;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            heat_q <= 1'b0;
            load_q <= 1'b0;
            oper_q <= 1'b0;
            wprev_q <= 3'h0;
        end
        else
        begin
            heat_q <= temp_i > temp_lim_q;
            load_q <= load_i > ovld_q;
            if (func_wr && |func_new)
                oper_q <= 1'b1;
            else if (!(|(func_q & term_s)))
                oper_q <= 1'b0;
            wprev_q <= {heat_q, load_q, oper_q};
        end
    end

    // ****************************************
    // Warning history
    // ****************************************
    logic [7:0] hist_q [0:8];
    logic [3:0] hcnt_q;
    logic [2:0] wrise;
    logic [7:0] ev_code;
    logic ev, rec;
    assign wrise = {heat_q, load_q, oper_q} & ~wprev_q;
    assign ev = |wrise;
    assign ev_code = wrise[2] ? mdw_pkg::WCODE_HEAT :
                     wrise[1] ? mdw_pkg::WCODE_LOAD : mdw_pkg::WCODE_OPER;
    // A clear in the same cycle empties first, so the new warning still lands
    assign rec = ev && (hclr || hcnt_q == 4'h0 || hist_q[0] != ev_code);

    // Newest entry in slot 0
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hist_q[0] <= 8'h00;
        else if (rec)
            hist_q[0] <= ev_code;
        else if (hclr)
            hist_q[0] <= 8'h00;
    end
    // Older entries shift down; the ninth falls off
    for (genvar i = 1; i < 9; i++)
    begin : g_hist
        always_ff @(posedge core_clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
                hist_q[i] <= 8'h00;
            else if (hclr)
                hist_q[i] <= 8'h00;
            else if (rec)
                hist_q[i] <= hist_q[i-1];
        end
    end
    // Entry count saturates at the depth
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hcnt_q <= 4'h0;
        else if (rec && hclr)
            hcnt_q <= 4'h1;
        else if (hclr)
            hcnt_q <= 4'h0;
        else if (rec && hcnt_q != mdw_pkg::HIST_DEPTH)
            hcnt_q <= hcnt_q + 4'h1;
    end

    // ****************************************
    // Alarm hold
    // ****************************************
    logic alarm_q, arst_prev_q, arst_fall;
    assign arst_fall = arst_prev_q && !arst_s && !fwd_s && !rev_s;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            alarm_q <= 1'b0;
            arst_prev_q <= 1'b0;
        end
        else
        begin
            arst_prev_q <= arst_s;
            if (alarm_s)
                alarm_q <= 1'b1; // Set beats reset
            else if (arst_fall || mon_arst)
                alarm_q <= 1'b0;
        end
    end

    // ****************************************
    // Speed dial
    // ****************************************
    logic [15:0] pend_q;
    logic [2:0] dprev_q;
    logic [31:0] edit_q;
    logic up_e, dn_e, pr_e, lock;
    assign up_e = up_s && !dprev_q[2];
    assign dn_e = dn_s && !dprev_q[1];
    assign pr_e = press_s && !dprev_q[0];
    assign lock = ctrl_q[mdw_pkg::CTRL_LOCK];
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dprev_q <= 3'h0;
            pend_q <= mdw_pkg::SPEED_RST;
            speed_set_q <= mdw_pkg::SPEED_RST;
            edit_q <= 32'h0;
        end
        else
        begin
            dprev_q <= {up_s, dn_s, press_s};
            if (lock)
                pend_q <= speed_set_q;
            else if (pr_e)
            begin
                speed_set_q <= pend_q;
                edit_q <= 32'h0;
            end
            else if (up_e && pend_q != 16'hFFFF)
            begin
                pend_q <= pend_q + mdw_pkg::DIAL_STEP;
                edit_q <= 32'h1;
            end
            else if (dn_e && pend_q != 16'h0000)
            begin
                pend_q <= pend_q - mdw_pkg::DIAL_STEP;
                edit_q <= 32'h1;
            end
            else if (edit_q == 32'(EDIT_TO_CYC))
            begin
                pend_q <= speed_set_q;
                edit_q <= 32'h0;
            end
            else if (edit_q != 32'h0)
                edit_q <= edit_q + 32'h1;
        end
    end

    // ****************************************
    // Run permission and outputs
    // ****************************************
    logic run_req, dir_req;
    always_comb
    begin
        run_req = 1'b0;
        dir_req = dsw_s;
        case (mode)
            mdw_pkg::EXT_ON:
            begin
                run_req = fwd_s ^ rev_s;
                dir_req = fwd_s ? dsw_s : !dsw_s;
            end
            mdw_pkg::EXT_DIR:
            begin
                run_req = fwd_s ^ rev_s;
                dir_req = fwd_s;
            end
            default:
            begin
                run_req = panel_s;
                dir_req = dsw_s;
            end
        endcase
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            motor_run_o <= 1'b0;
            motor_dir_o <= 1'b0;
            speed_cmd_o <= mdw_pkg::SPEED_RST;
            warning_out_o <= 1'b0;
        end
        else
        begin
            motor_run_o <= run_req && !alarm_q && !alarm_s && !oper_q;
            motor_dir_o <= dir_req;
            if (speed_set_q > upper_q)
                speed_cmd_o <= upper_q;
            else if (speed_set_q < lower_q)
                speed_cmd_o <= lower_q;
            else
                speed_cmd_o <= speed_set_q;
            warning_out_o <= ctrl_q[mdw_pkg::CTRL_ASSIGN] && (heat_q || load_q || oper_q);
        end
    end

    // ****************************************
    // Bus answer and read data
    // ****************************************
    logic [31:0] rd;
    logic [7:0] hofs;
    assign hofs = wb_adr_i - mdw_pkg::ADR_HIST;
    always_comb
    begin
        rd = 32'h0;
        case (wb_adr_i)
            mdw_pkg::ADR_CTRL: rd = {24'h0, ctrl_q};
            mdw_pkg::ADR_STAT: rd = {20'h0, hcnt_q, 2'h0, motor_dir_o, motor_run_o,
                                     alarm_q, heat_q, load_q, oper_q};
            mdw_pkg::ADR_IOMON: rd = {16'h0, warning_out_o, motor_dir_o, motor_run_o,
                                      pin_s};
            mdw_pkg::ADR_UPPER: rd = {16'h0, upper_q};
            mdw_pkg::ADR_LOWER: rd = {16'h0, lower_q};
            mdw_pkg::ADR_OVLD: rd = {24'h0, ovld_q};
            mdw_pkg::ADR_TEMP: rd = {24'h0, temp_lim_q};
            mdw_pkg::ADR_SPEED: rd = {speed_set_q, speed_cmd_o};
            mdw_pkg::ADR_FUNC: rd = {28'h0, func_q};
            default:
            begin
                if (hofs[1:0] == 2'h0 && hofs[7:2] < 6'h9)
                    rd = {24'h0, hist_q[hofs[5:2]]};
            end
        endcase
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end
        else
        begin
            ack_q <= req;
            if (req)
                dat_q <= rd;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_warn_on;
        (heat_q || load_q || oper_q) && ctrl_q[mdw_pkg::CTRL_ASSIGN] |=> warning_out_o;
    endproperty
    a_warn_on: assert property (p_warn_on) else $error("warning not raised");
    property p_warn_hidden;
        !ctrl_q[mdw_pkg::CTRL_ASSIGN] |=> !warning_out_o;
    endproperty
    a_warn_hidden: assert property (p_warn_hidden) else $error("warning unassigned");
    property p_heat;
        temp_i > temp_lim_q ##1 (run_req && !alarm_q && !alarm_s && !oper_q) |=> motor_run_o;
    endproperty
    a_heat: assert property (p_heat) else $error("overheat stopped motor");
    property p_oper_stop;
        oper_q |=> !motor_run_o;
    endproperty
    a_oper_stop: assert property (p_oper_stop) else $error("run during op error");
    property p_depth;
        (rec && !hclr && hcnt_q != mdw_pkg::HIST_DEPTH |=> hcnt_q == $past(hcnt_q) + 4'h1)
            and hcnt_q <= mdw_pkg::HIST_DEPTH;
    endproperty
    a_depth: assert property (p_depth) else $error("history count wrong");
    property p_dup;
        ev && !hclr && hcnt_q != 4'h0 && hist_q[0] == ev_code |=> $stable(hcnt_q);
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate recorded");
    property p_clear;
        hclr && !ev |=> hcnt_q == 4'h0 && hist_q[0] == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("history not cleared");
    property p_pair;
        (mode == mdw_pkg::EXT_ON || mode == mdw_pkg::EXT_DIR) && fwd_s == rev_s |=> !motor_run_o;
    endproperty
    a_pair: assert property (p_pair) else $error("run with bad inputs");
    property p_alarm;
        alarm_q |=> !motor_run_o;
    endproperty
    a_alarm: assert property (p_alarm) else $error("run during alarm");
    property p_clamp;
        upper_q >= lower_q ##1 $stable(upper_q) && $stable(lower_q)
            |-> speed_cmd_o <= upper_q && speed_cmd_o >= lower_q;
    endproperty
    a_clamp: assert property (p_clamp) else $error("speed out of limits");
endmodule : mdw_monitor

// ---- mdw_ctrl_model.sv ----
// Purpose: External controller model driving the forward and reverse run inputs
// Assumes: Bench commands change just after a rising clock edge
// Notes: Slow mode holds each change back by three cycles
`timescale 1ns/1ps
module mdw_ctrl_model (
    // Clock
    input wire logic core_clk_i,
    // Commands from the bench, bit 0 forward, bit 1 reverse
    input wire logic [1:0] run_req_i,
    input wire logic slow_i,
    // Run inputs of the drive
    output logic forward_run_in_o,
    output logic reverse_run_in_o
);
    logic [1:0] req_q = 2'h0;
    logic [1:0] wait_q = 2'h0;
    // ****************************************
    // Run input drive
    // ****************************************
    // Follow the command, late when slow; both on only when commanded
    always_ff @(posedge core_clk_i)
    begin
        if (run_req_i != req_q && slow_i && wait_q != 2'h3)
        begin
            wait_q <= wait_q + 2'h1;
        end
        else
        begin
            wait_q <= 2'h0;
            req_q <= run_req_i;
        end
    end
    assign forward_run_in_o = req_q[0];
    assign reverse_run_in_o = req_q[1];
endmodule : mdw_ctrl_model

// ---- mdw_monitor_bench.sv ----
// Purpose: Self-checking bench of the warning monitor
// Assumes: Ack one cycle after a request, pins seen three edges after a change
// Notes: Dial edit timeout shortened to 100 cycles
`timescale 1ns/1ps
module mdw_monitor_bench;
    logic clk, rst_n, cyc, stb, we, ack, run, dir, warning_out, slow, panel, dsw;
    logic arst, alarm, up, down, press, forward_run_in, reverse_run_in;
    logic [1:0] req;
    logic [3:0] term;
    logic [7:0] adr, temp, load;
    logic [15:0] spd;
    logic [31:0] wdat, rdat;
    int bad_count = 0;
    int compares = 0;
    // ****************************************
    // Design, controller model and clock
    // ****************************************
    mdw_monitor #(.EDIT_TO_CYC(100)) mdw_monitor_i (.core_clk_i(clk), .rst_n_i(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .forward_run_in_i(forward_run_in),
        .reverse_run_in_i(reverse_run_in), .panel_run_i(panel), .dir_switch_i(dsw),
        .alarm_reset_in_i(arst), .alarm_in_i(alarm), .dial_up_i(up), .dial_down_i(down),
        .dial_press_i(press), .term_in_i(term), .temp_i(temp), .load_i(load),
        .motor_run_o(run), .motor_dir_o(dir), .speed_cmd_o(spd), .warning_out_o(warning_out));
    mdw_ctrl_model mdw_ctrl_model_i (.core_clk_i(clk), .run_req_i(req), .slow_i(slow),
        .forward_run_in_o(forward_run_in), .reverse_run_in_o(reverse_run_in));
    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Classic single Wishbone cycle, held until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1)
        begin
            bad_count++;
            $display("unexpected ack expected 1 seen %b", ack);
            print_verdict();
        end
    endtask : wb_xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, q);
        tick(5);
    endtask : wr
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic chk_pin(input string what, input logic e, input logic g);
        chk(what, {31'h0, e}, {31'h0, g});
    endtask : chk_pin
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb_xfer(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), e, q & m);
    endtask : rd
    // One dial action: step up and/or press
    task automatic dial(input logic u, input logic p);
        up <= u;
        press <= p;
        tick(4);
        up <= 1'b0;
        press <= 1'b0;
        tick(4);
    endtask : dial
    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        {rst_n, cyc, stb, we, slow, panel, dsw, arst, alarm, up, down, press} = 12'h0;
        {req, term, adr, temp, load, wdat} = 62'h0;
        tick(4);
        rst_n <= 1'b1;
        rd(mdw_pkg::ADR_STAT, 32'hFFFFFFFF, 32'h0);
        rd(mdw_pkg::ADR_UPPER, 32'hFFFF, 32'h0FA0);
        rd(mdw_pkg::ADR_SPEED, 32'hFFFFFFFF, 32'h00500050);
        rd(8'h80, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
        wr(mdw_pkg::ADR_CTRL, 32'h1);
        req <= 2'h1;
        tick(6);
        chk_pin("run fwd", 1'b1, run);
        chk_pin("dir fwd", 1'b0, dir);
        req <= 2'h3;
        tick(6);
        chk_pin("run both", 1'b0, run);
        slow <= 1'b1;
        req <= 2'h2;
        tick(10);
        chk_pin("dir rev", 1'b1, dir);
        wr(mdw_pkg::ADR_CTRL, 32'h2);
        dsw <= 1'b1;
        tick(6);
        chk_pin("run dirmode", 1'b1, run);
        chk_pin("dir dirmode", 1'b0, dir);
        // Mode three falls back to panel operation
        wr(mdw_pkg::ADR_CTRL, 32'h3);
        chk_pin("run idle", 1'b0, run);
        panel <= 1'b1;
        tick(6);
        chk_pin("run panel", 1'b1, run);
        rd(mdw_pkg::ADR_IOMON, 32'hFFFF, 32'h6E00);
        $display("test run control done");
        temp <= 8'h56;
        tick(6);
        chk_pin("warn unassigned", 1'b0, warning_out);
        chk_pin("run heat", 1'b1, run);
        rd(mdw_pkg::ADR_HIST, 32'hFF, 32'h51);
        wr(mdw_pkg::ADR_CTRL, 32'h4);
        chk_pin("warn", 1'b1, warning_out);
        load <= 8'hC9;
        tick(6);
        load <= 8'h0;
        tick(6);
        load <= 8'hC9;
        tick(6);
        rd(mdw_pkg::ADR_HIST + 8'h4, 32'hFF, 32'h51);
        rd(mdw_pkg::ADR_STAT, 32'hF06, 32'h206);
        wr(mdw_pkg::ADR_CTRL, 32'h14);
        rd(mdw_pkg::ADR_STAT, 32'hF00, 32'h0);
        {temp, load} <= 16'h0;
        tick(6);
        chk_pin("warn off", 1'b0, warning_out);
        for (int i = 0; i < 10; i++)
        begin
            if (i % 2 == 0)
                temp <= 8'h56;
            else
                load <= 8'hC9;
            tick(6);
            {temp, load} <= 16'h0;
            tick(6);
        end
        rd(mdw_pkg::ADR_STAT, 32'hF00, 32'h900);
        rd(mdw_pkg::ADR_HIST + 8'h20, 32'hFF, 32'h30);
        term <= 4'h1;
        tick(6);
        wr(mdw_pkg::ADR_FUNC, 32'h1);
        rd(mdw_pkg::ADR_STAT, 32'h11, 32'h1);
        rd(mdw_pkg::ADR_HIST, 32'hFF, 32'h6C);
        term <= 4'h0;
        wr(mdw_pkg::ADR_FUNC, 32'h0);
        $display("test warnings done");
        wr(mdw_pkg::ADR_CTRL, 32'h1);
        {slow, req, alarm} <= 4'h3;
        tick(6);
        alarm <= 1'b0;
        arst <= 1'b1;
        tick(6);
        arst <= 1'b0;
        tick(6);
        chk_pin("run alarm", 1'b0, run);
        req <= 2'h0;
        arst <= 1'b1;
        tick(6);
        arst <= 1'b0;
        req <= 2'h1;
        tick(8);
        chk_pin("run reset", 1'b1, run);
        alarm <= 1'b1;
        tick(6);
        alarm <= 1'b0;
        tick(6);
        chk_pin("run held", 1'b0, run);
        wr(mdw_pkg::ADR_CTRL, 32'h21);
        chk_pin("run bus reset", 1'b1, run);
        $display("test alarm done");
        wr(mdw_pkg::ADR_UPPER, 32'h40);
        rd(mdw_pkg::ADR_SPEED, 32'hFFFF, 32'h40);
        chk("speed pin", 32'h40, {16'h0, spd});
        wr(mdw_pkg::ADR_UPPER, 32'h0FA0);
        wr(mdw_pkg::ADR_LOWER, 32'h60);
        rd(mdw_pkg::ADR_SPEED, 32'hFFFF, 32'h60);
        wr(mdw_pkg::ADR_LOWER, 32'h50);
        repeat (3) dial(1'b1, 1'b0);
        dial(1'b0, 1'b1);
        rd(mdw_pkg::ADR_SPEED, 32'hFFFFFFFF, 32'h00530053);
        dial(1'b1, 1'b0);
        tick(120);
        dial(1'b0, 1'b1);
        rd(mdw_pkg::ADR_SPEED, 32'hFFFF0000, 32'h00530000);
        wr(mdw_pkg::ADR_CTRL, 32'h9);
        dial(1'b1, 1'b0);
        dial(1'b0, 1'b1);
        rd(mdw_pkg::ADR_SPEED, 32'hFFFF0000, 32'h00530000);
        wr(mdw_pkg::ADR_CTRL, 32'h1);
        down <= 1'b1;
        tick(4);
        down <= 1'b0;
        tick(4);
        dial(1'b0, 1'b1);
        rd(mdw_pkg::ADR_SPEED, 32'hFFFFFFFF, 32'h00520052);
        $display("test speed done");
        print_verdict();
    end
endmodule : mdw_monitor_bench
